/* File: dv/fdhp_device_model.sv */
// behavioural flash disk device that answers the controller's pins
`timescale 1ns/1ps
`default_nettype none
module fdhp_device_model #(
    parameter int BUSY_NS = 1550            // load time, off the clock edge
) (
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic        avd_n_in,
    input  wire logic [12:0] addr_in,
    input  wire logic        ubs_n_in,
    input  wire logic        width_in,
    input  wire logic        por_n_in,
    input  wire logic [15:0] host_data_in,
    input  wire logic        irq_trig_in,
    output logic [15:0]      data_out,
    output logic             busy_n_out = 1'b0,
    output logic             irq_n_out
);
    // ===========================================================
    // storage and lane decode
    logic [7:0]  mem [0:8191];
    logic [12:0] mux_addr = 13'h0000;
    logic        mux_on = 1'b0;
    logic [15:0] last = 16'h0000;           // released lines show ~last
    wire  [12:0] a = mux_on ? mux_addr : addr_in;
    wire  [12:0] lo = {a[12:1], 1'b0};
    wire         wide = mux_on || width_in;
    wire         hi_act = mux_on || (width_in && !ubs_n_in);
    wire         lo_act = mux_on || !a[0];
    wire  [15:0] rd = !wide ? {8'hff, mem[a]} :
                 {hi_act ? mem[lo | 13'h1] : ~last[15:8],
                  lo_act ? mem[lo] : ~last[7:0]};
    initial for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
    assign data_out = (!ce_n_in && !oe_n_in) ? rd : ~last;
    assign irq_n_out = !irq_trig_in;
    always @(posedge oe_n_in) last <= rd;
    // writes land on the write strobe's rising edge only
    always @(posedge we_n_in) begin
        if (!ce_n_in && !wide) mem[a] <= host_data_in[7:0];
        if (!ce_n_in && wide && lo_act) mem[lo] <= host_data_in[7:0];
        if (!ce_n_in && wide && hi_act) mem[lo | 13'h1] <= host_data_in[15:8];
    end
    always @(negedge avd_n_in or negedge por_n_in) mux_on <= por_n_in;
    // address taken a little after the fall, once the lines have settled
    always @(negedge avd_n_in) #10 mux_addr = host_data_in[12:0];
    always @(por_n_in) begin
        busy_n_out = 1'b0;
        if (por_n_in === 1'b1) #(BUSY_NS) busy_n_out = por_n_in;
    end
endmodule
`default_nettype wire

/* File: dv/fdhp_host_asserts.sv */
// concurrent checks on the flash disk host controller ports
`timescale 1ns/1ps
`default_nettype none
module fdhp_host_asserts (
    input wire logic       mclk_in,
    input wire logic       rst_in,
    input wire logic       req_in,
    input wire logic [1:0] req_lanes_in,
    input wire logic       ready_out,
    input wire logic       done_out,
    input wire logic       mux_mode_in,
    input wire logic       wide_mode_in,
    input wire logic       word_only_in,
    input wire logic       lock_req_in,
    input wire logic       busy_n_in,
    input wire logic       output_enable_n_out,
    input wire logic       write_enable_n_out,
    input wire logic       lock_n_out,
    input wire logic [1:0] chip_identity_straps_out,
    input wire logic       irq_n_in,
    input wire logic       irq_seen_out,
    input wire logic       chip_enable_n_out,
    input wire logic       address_valid_n_out,
    input wire logic       data_oe_out
);
    // ===========================================================
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence take_s;
        req_in && ready_out;
    endsequence
    sequence noop_s;
        take_s ##0 (wide_mode_in && !mux_mode_in && !word_only_in
            && req_lanes_in == 2'h0);
    endsequence
    chk_straps_low: assert property (chip_identity_straps_out == 2'h0)
        else $error("identity straps not low");
    chk_lock_follow: assert property ($stable(lock_req_in) [*3]
        |-> lock_n_out == !lock_req_in) else $error("lock pin wrong");
    chk_strobe_excl: assert property (output_enable_n_out
        || write_enable_n_out) else $error("both strobes low");
    chk_noop_quiet: assert property (noop_s |=>
        (output_enable_n_out && write_enable_n_out) [*6])
        else $error("strobe on empty lane cycle");
    chk_done_bound: assert property (take_s |-> ##[3:7] done_out)
        else $error("cycle did not finish");
    chk_take_drop: assert property (take_s |=> ##1 !ready_out)
        else $error("ready held during a cycle");
    chk_busy_block: assert property (!busy_n_in [*4] |-> !ready_out)
        else $error("ready while device busy");
    chk_irq_seen: assert property (irq_seen_out == !$past(irq_n_in))
        else $error("interrupt view wrong");
    chk_addr_drive: assert property (!address_valid_n_out
        && !chip_enable_n_out |-> data_oe_out)
        else $error("address phase not driven");
endmodule
bind fdhp_host fdhp_host_asserts chk (.*);
`default_nettype wire

/* File: dv/fdhp_host_tb.sv */
// self-checking testbench for the flash disk host controller
`timescale 1ns/1ps
`default_nettype none
module fdhp_host_tb;
    // ===========================================================
    logic        mclk_in = 1'b0, rst_in = 1'b1, irq_trig = 1'b0;
    logic        req_in = 1'b0, req_write_in = 1'b0, mux_mode_in = 1'b0;
    logic        wide_mode_in = 1'b0, word_only_in = 1'b0, lock_req_in = 1'b0;
    logic [12:0] req_addr_in = 13'h0000;
    logic [1:0]  req_lanes_in = 2'h3;
    logic [15:0] req_wdata_in = 16'h0000;
    wire logic   ready_out, done_out, irq_seen_out, chip_enable_n_out;
    wire logic   output_enable_n_out, write_enable_n_out, address_valid_n_out;
    wire logic   upper_byte_select_n_out, width_select_out, lock_n_out;
    wire logic   power_on_reset_n_out, data_oe_out, busy_n_in, irq_n_in;
    wire logic [12:0] addr_out;
    wire logic [1:0]  chip_identity_straps_out;
    wire logic [15:0] rdata_out, data_out, data_in;
    logic [7:0]  ref_mem [0:8191];          // bench copy of device bytes
    logic [31:0] seed = 32'he518c903;
    int          fail_count = 0, checks = 0;
    always #50 mclk_in = ~mclk_in;
    fdhp_host uut (.*);
    fdhp_device_model dev (.ce_n_in(chip_enable_n_out),
        .oe_n_in(output_enable_n_out), .we_n_in(write_enable_n_out),
        .avd_n_in(address_valid_n_out), .addr_in(addr_out),
        .ubs_n_in(upper_byte_select_n_out), .width_in(width_select_out),
        .por_n_in(power_on_reset_n_out), .host_data_in(data_out),
        .irq_trig_in(irq_trig), .data_out(data_in), .busy_n_out(busy_n_in),
        .irq_n_out(irq_n_in));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one request, bounded waits; reads compared on the active lanes
    task automatic xfer(input logic w, input logic [12:0] a,
                        input logic [1:0] ln, input logic [15:0] d);
        logic        bm;
        logic [1:0]  eff;
        logic [12:0] lo;
        logic [15:0] m, e;
        int          n;
        bm = !wide_mode_in && !mux_mode_in;
        eff = (mux_mode_in || word_only_in) ? 2'h3 : ln;
        lo = {a[12:1], 1'b0};
        m = bm ? 16'hffff : {{8{eff[1]}}, {8{eff[0]}}};
        e = bm ? {8'h00, ref_mem[a]} : {ref_mem[lo | 13'h1], ref_mem[lo]};
        // let a mode change reach ready_out before trusting it
        @(negedge mclk_in);
        for (n = 0; n < 80 && ready_out !== 1'b1; n++) @(negedge mclk_in);
        check({15'h0, ready_out}, 16'h1);
        {req_in, req_write_in, req_addr_in} = {1'b1, w, a};
        req_lanes_in = ln;
        req_wdata_in = d;
        @(negedge mclk_in);
        req_in = 1'b0;
        for (n = 0; n < 12 && done_out !== 1'b1; n++) @(negedge mclk_in);
        check({15'h0, done_out}, 16'h1);
        if (!w) check(rdata_out & m, e & m);
        if (w && bm) ref_mem[a] = d[7:0];
        if (w && !bm && eff[0]) ref_mem[lo] = d[7:0];
        if (w && !bm && eff[1]) ref_mem[lo | 13'h1] = d[15:8];
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #500000;
        fail_count++;
        wrap_up();
    end
    // ===========================================================
    initial begin
        for (int i = 0; i < 8192; i++) ref_mem[i] = 8'h00;
        repeat (12) @(negedge mclk_in);
        rst_in = 1'b0;
        check({14'h0, chip_identity_straps_out}, 16'h0);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            xfer(1'b1, seed[12:0], 2'h3, seed[31:16]);
            xfer(1'b0, seed[12:0], 2'h3, 16'h0000);
        end
        $display("test byte mode done");
        wide_mode_in = 1'b1;
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            xfer(1'b1, seed[12:0], 2'(i), seed[31:16]);
            xfer(1'b0, seed[12:0], 2'h3, 16'h0000);
            xfer(1'b0, seed[12:0], 2'(i), 16'h0000);
        end
        word_only_in = 1'b1;
        seed = xs(seed);
        xfer(1'b1, seed[12:0], 2'h1, seed[31:16]);
        word_only_in = 1'b0;
        xfer(1'b0, seed[12:0], 2'h3, 16'h0000);
        $display("test word mode done");
        lock_req_in = 1'b1;
        irq_trig = 1'b1;
        repeat (4) @(negedge mclk_in);
        check({15'h0, lock_n_out}, 16'h0);
        check({15'h0, irq_seen_out}, 16'h1);
        lock_req_in = 1'b0;
        irq_trig = 1'b0;
        $display("test lock and interrupt done");
        mux_mode_in = 1'b1;
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            xfer(1'b1, seed[12:0], 2'h3, seed[31:16]);
            xfer(1'b0, seed[12:0], 2'h3, 16'h0000);
        end
        rst_in = 1'b1;
        @(negedge mclk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        check({15'h0, ready_out}, 16'h0);
        xfer(1'b0, seed[12:0], 2'h3, 16'h0000);
        $display("test multiplexed mode done");
        wrap_up();
    end
endmodule
`default_nettype wire

/* File: hdl/fdhp_host.sv */
// host-side controller that drives the flash disk bus pins
// Operation
// (RULE1) width select low 8-bit, high 16-bit
// (RULE2) 8-bit mode uses only low data lane
// (RULE3) upper select and bit zero pick lanes
// (RULE4) both high means no transfer
// (RULE5) word-only host may tie selects low
// (RULE6) boot block answers byte and word reads
// (RULE7) upper select matters only during boot
// (RULE8) 32-bit host maps bit one, ties zero
// (RULE9) low lane carries least significant byte
// (RULE10) address-valid fall enters multiplexed mode
// (RULE11) host pulses address-valid before first read
// (RULE12) multiplexed: address on data, pins low
// (RULE13) one clean edge per strobe
// (RULE14) device holds busy during load
// (RULE15) host waits for busy release first
// (RULE16) lock input blocks protection disable
// (RULE17) interrupt source and sense selectable; here fixed, irq_n_in sampled as an active-low level only
// (RULE18) software arms interrupt before long operation
// (RULE19) single device ties identity straps low
// (RULE20) thirteen address bits in 8KB window
// (RULE21) interrupt output is active low
`timescale 1ns/1ps
`default_nettype none
module fdhp_host (
    input  wire logic                        mclk_in,
    input  wire logic                        rst_in,
    // user side
    input  wire logic                        req_in,
    input  wire logic                        req_write_in,
    input  wire logic [fdhp_pkg::ADDR_W-1:0] req_addr_in,
    input  wire logic [1:0]                  req_lanes_in,
    input  wire logic [fdhp_pkg::DATA_W-1:0] req_wdata_in,
    input  wire logic                        mux_mode_in,
    input  wire logic                        wide_mode_in,
    input  wire logic                        word_only_in,
    input  wire logic                        lock_req_in,
    output logic                             ready_out,
    output logic                             done_out,
    output logic [fdhp_pkg::DATA_W-1:0]      rdata_out,
    output logic                             irq_seen_out,
    // device pins
    output logic                             chip_enable_n_out,
    output logic                             output_enable_n_out,
    output logic                             write_enable_n_out,
    output logic                             address_valid_n_out,
    output logic [fdhp_pkg::ADDR_W-1:0]      addr_out,
    output logic                             upper_byte_select_n_out,
    output logic                             width_select_out,
    output logic                             lock_n_out,
    output logic                             power_on_reset_n_out,
    output logic [1:0]                       chip_identity_straps_out,
    output logic [fdhp_pkg::DATA_W-1:0]      data_out,
    output logic                             data_oe_out,
    input  wire logic [fdhp_pkg::DATA_W-1:0] data_in,
    input  wire logic                        busy_n_in,
    input  wire logic                        irq_n_in
);
    // ===========================================================
    // lane helper
    // lanes: bit1 upper byte, bit0 lower byte; returns select/bit0
    function automatic logic [1:0] fdhp_lane_pins(input logic [1:0] ln);
        // both lanes -> 00, upper only -> 01, lower only -> 10
        unique case (ln)
            2'b11:   fdhp_lane_pins = 2'b00;    // RULE3
            2'b10:   fdhp_lane_pins = 2'b01;    // RULE3
            2'b01:   fdhp_lane_pins = 2'b10;    // RULE3
            default: fdhp_lane_pins = 2'b11;    // RULE4
        endcase
    endfunction
    // ===========================================================
    // registers
    fdhp_pkg::fdhp_state_t state_reg, state_next;
    logic [fdhp_pkg::CNT_W-1:0]  cnt_reg, cnt_next;   // phase timer
    logic                        wr_reg;              // latched direction
    logic [fdhp_pkg::ADDR_W-1:0] addr_reg;            // latched address
    logic [1:0]                  pins_reg;            // select, bit zero
    logic [fdhp_pkg::DATA_W-1:0] wdata_reg;           // latched write data
    logic                        muxed_reg;           // mux protocol live
    logic                        muxed_entered_reg;   // first fall sent
    logic                        rst_done_reg;        // reset released
    // ===========================================================
    // decode
    wire logic [1:0] req_pins = word_only_in ? 2'b00       // RULE5 RULE8
                              : !wide_mode_in ? {1'b1, req_addr_in[0]}
                              : fdhp_lane_pins(req_lanes_in);
    // busy high means device ready for first access
    wire logic dev_ready = busy_n_in && rst_done_reg;      // RULE15
    wire logic take      = req_in && dev_ready
                         && state_reg == fdhp_pkg::FDHP_IDLE
                         && !(mux_mode_in && !muxed_entered_reg);
    wire logic need_wake = mux_mode_in && !muxed_entered_reg && dev_ready
                         && state_reg == fdhp_pkg::FDHP_IDLE;
    wire logic cnt_done  = cnt_reg == '0;
    wire logic noop      = pins_reg == 2'b11 && wide_mode_in && !muxed_reg;
    // request fields as the pins must show them: on the taking edge the
    // latches still hold the old cycle, so without this the first phase
    // would carry a stale address, direction and protocol
    wire logic wr_cur    = take ? req_write_in : wr_reg;
    wire logic muxed_cur = take ? mux_mode_in : muxed_reg;
    wire logic [1:0] pins_cur = take ? req_pins : pins_reg;
    wire logic [fdhp_pkg::ADDR_W-1:0] addr_cur =
        take ? req_addr_in : addr_reg;
    wire logic [fdhp_pkg::DATA_W-1:0] wdata_cur =
        take ? req_wdata_in : wdata_reg;
    wire logic noop_cur  = pins_cur == 2'b11 && wide_mode_in && !muxed_cur;
    wire logic [fdhp_pkg::CNT_W-1:0] c_setup =
        fdhp_pkg::CNT_W'(fdhp_pkg::SETUP_CYC - 1);
    wire logic [fdhp_pkg::CNT_W-1:0] c_strobe =
        fdhp_pkg::CNT_W'(fdhp_pkg::STROBE_CYC - 1);
    wire logic [fdhp_pkg::CNT_W-1:0] c_hold =
        fdhp_pkg::CNT_W'(fdhp_pkg::HOLD_CYC - 1);
    wire logic [fdhp_pkg::CNT_W-1:0] c_avd =
        fdhp_pkg::CNT_W'(fdhp_pkg::AVD_CYC - 1);
    // ===========================================================
    // next-state logic
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_done ? cnt_reg : cnt_reg - 1'b1;
        unique case (state_reg)
            fdhp_pkg::FDHP_IDLE: begin
                if (need_wake) begin               // RULE11
                    state_next = fdhp_pkg::FDHP_WAKE;
                    cnt_next   = c_avd;
                end else if (take) begin
                    // multiplexed cycles open with an address phase
                    state_next = mux_mode_in ? fdhp_pkg::FDHP_AVD
                                             : fdhp_pkg::FDHP_SETUP;
                    cnt_next   = mux_mode_in ? c_avd : c_setup;
                end
            end
            fdhp_pkg::FDHP_WAKE: begin
                if (cnt_done) state_next = fdhp_pkg::FDHP_IDLE;
            end
            fdhp_pkg::FDHP_AVD: begin
                if (cnt_done) begin
                    state_next = fdhp_pkg::FDHP_SETUP;
                    cnt_next   = c_setup;
                end
            end
            fdhp_pkg::FDHP_SETUP: begin
                if (cnt_done) begin
                    state_next = fdhp_pkg::FDHP_STROBE;
                    cnt_next   = c_strobe;
                end
            end
            fdhp_pkg::FDHP_STROBE: begin
                if (cnt_done) begin
                    state_next = fdhp_pkg::FDHP_HOLD;
                    cnt_next   = c_hold;
                end
            end
            fdhp_pkg::FDHP_HOLD: begin
                if (cnt_done) state_next = fdhp_pkg::FDHP_IDLE;
            end
            default: state_next = fdhp_pkg::FDHP_IDLE;
        endcase
    end
    // ===========================================================
    // pin values for the next cycle
    wire logic in_strobe = state_next == fdhp_pkg::FDHP_STROBE;
    wire logic ce_next  = state_next != fdhp_pkg::FDHP_IDLE
                       && state_next != fdhp_pkg::FDHP_WAKE;
    wire logic avd_next = state_next == fdhp_pkg::FDHP_AVD
                       || state_next == fdhp_pkg::FDHP_WAKE;  // RULE10
    // strobe only once per cycle, never on a no-op
    wire logic oe_next  = in_strobe && !wr_cur && !noop_cur; // RULE13
    wire logic we_next  = in_strobe && wr_cur && !noop_cur;  // RULE13
    // address on AD lines during address phase, data on writes
    wire logic ad_drive = state_next == fdhp_pkg::FDHP_AVD;
    wire logic dd_drive = wr_cur && !noop_cur && ce_next
                       && state_next != fdhp_pkg::FDHP_AVD;
    // 8-bit mode: only low lane driven; data stays little endian
    wire logic [fdhp_pkg::DATA_W-1:0] wdata_lanes =
        (!muxed_cur && !wide_mode_in) ? {8'h00, wdata_cur[7:0]}   // RULE2
                                      : wdata_cur;                // RULE9
    // read capture, narrowed the same way
    wire logic [fdhp_pkg::DATA_W-1:0] rdata_lanes =
        (!muxed_reg && !wide_mode_in) ? {8'h00, data_in[7:0]}     // RULE2
                                      : data_in;                  // RULE6
    wire logic capture = state_reg == fdhp_pkg::FDHP_STROBE && cnt_done
                      && !wr_reg;
    // ===========================================================
    // sequencer and request latches
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg         <= fdhp_pkg::FDHP_IDLE;
            cnt_reg           <= '0;
            wr_reg            <= 1'b0;
            addr_reg          <= '0;
            pins_reg          <= 2'b00;
            wdata_reg         <= '0;
            muxed_reg         <= 1'b0;
            muxed_entered_reg <= 1'b0;
            rst_done_reg      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            rst_done_reg <= 1'b1;
            if (take) begin
                wr_reg    <= req_write_in;
                addr_reg  <= req_addr_in;
                pins_reg  <= req_pins;
                wdata_reg <= req_wdata_in;
                muxed_reg <= mux_mode_in;
            end
            // first fall of address-valid switches the device
            if (state_reg == fdhp_pkg::FDHP_WAKE)
                muxed_entered_reg <= 1'b1;         // RULE10
        end
    end
    // ===========================================================
    // registered pin drivers
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            chip_enable_n_out       <= 1'b1;
            output_enable_n_out     <= 1'b1;
            write_enable_n_out      <= 1'b1;
            address_valid_n_out     <= 1'b1;
            addr_out                <= '0;
            upper_byte_select_n_out <= 1'b0;
            data_out                <= '0;
            data_oe_out             <= 1'b0;
        end else begin
            chip_enable_n_out   <= !ce_next;                 // RULE20
            output_enable_n_out <= !oe_next;
            write_enable_n_out  <= !we_next;
            address_valid_n_out <= !avd_next;
            data_oe_out         <= ad_drive || dd_drive;
            if (muxed_cur || state_next == fdhp_pkg::FDHP_WAKE) begin
                // address pins and upper select tied low
                addr_out                <= '0;               // RULE12
                upper_byte_select_n_out <= 1'b0;             // RULE12
                data_out <= ad_drive ? {3'b000, addr_cur} : wdata_lanes;
            end else begin
                // lane choice rides on address bit zero
                addr_out <= {addr_cur[fdhp_pkg::ADDR_W-1:1], pins_cur[0]};
                upper_byte_select_n_out <= pins_cur[1];      // RULE7
                data_out                <= wdata_lanes;
            end
        end
    end
    // ===========================================================
    // user-side answers and static straps
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ready_out                <= 1'b0;
            done_out                 <= 1'b0;
            rdata_out                <= '0;
            irq_seen_out             <= 1'b0;
            width_select_out         <= 1'b0;
            lock_n_out               <= 1'b1;
            power_on_reset_n_out     <= 1'b0;
            chip_identity_straps_out <= 2'b00;
        end else begin
            power_on_reset_n_out <= 1'b1;            // release after reset
            ready_out    <= dev_ready && state_next == fdhp_pkg::FDHP_IDLE
                         && !(mux_mode_in && !muxed_entered_reg); // RULE14
            done_out     <= state_reg == fdhp_pkg::FDHP_HOLD && cnt_done;
            if (capture && !noop)
                rdata_out <= rdata_lanes;
            // interrupt is active low, sampled as a level
            irq_seen_out <= !irq_n_in;                         // RULE21
            width_select_out <= wide_mode_in || mux_mode_in;   // RULE1
            lock_n_out   <= !lock_req_in;                      // RULE16
            chip_identity_straps_out <= 2'b00;                 // RULE19
        end
    end
endmodule
`default_nettype wire

/* File: pkg/fdhp_pkg.sv */
// package: constants for the flash disk host-side bus controller
package fdhp_pkg;
    // ===========================================================
    // widths
    localparam int ADDR_W = 13;                 // 8KB window
    localparam int DATA_W = 16;                 // device data lanes
    // ===========================================================
    // timing in ns and cycles at 10 MHz
    localparam int CLK_NS         = 100;        // mclk period
    localparam int SETUP_NS       = 100;        // address setup before strobe
    localparam int STROBE_NS      = 200;        // strobe low time
    localparam int HOLD_NS        = 100;        // hold after strobe rise
    localparam int AVD_NS         = 100;        // address valid low time
    localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int AVD_CYC    = (AVD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W      = 4;              // timer width
    // ===========================================================
    // sequencer states, gray from FDHP_AVD through FDHP_HOLD
    typedef enum logic [2:0] {
        FDHP_IDLE   = 3'b000,
        FDHP_AVD    = 3'b001,
        FDHP_SETUP  = 3'b011,
        FDHP_STROBE = 3'b010,
        FDHP_HOLD   = 3'b110,
        FDHP_WAKE   = 3'b111
    } fdhp_state_t;
endpackage
